// ---- clock_switch_and_prescaler.sv ----
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module clock_switch_and_prescaler #(
    parameter int START_EDGE_COUNT = 6
) (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic [1:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic [3:0] FUSE_CLOCK_SELECT_FUSES_I,
    input wire logic [1:0] FUSE_SUT_I,
    input wire logic FUSE_DIVIDE_BY_EIGHT_FUSE_I,
    input wire logic FUSE_CLOCK_OUTPUT_FUSE_I,
    input wire logic RC_CLK_I,
    input wire logic EXT_CLK_I,
    input wire logic GPIO_OUT_I,
    input wire logic GPIO_OE_I,
    output logic RC_EN_O,
    output logic EXT_EN_O,
    output logic [1:0] RC_SUT_O,
    output logic [1:0] EXT_SUT_O,
    output logic [3:0] RC_CLOCK_SELECT_FUSES_O,
    output logic [3:0] EXT_CLOCK_SELECT_FUSES_O,
    output logic SYS_CLK_O,
    output logic CLOCK_OUTPUT_PIN_O,
    output logic CLOCK_OUTPUT_PIN_OE_O
);
    import clkctl_pkg::*;

    // Pin synchronisers; no reset so the clock output path works in reset
    logic [9:0] sync0;
    logic [9:0] sync1;
    logic [9:0] sync2;
    logic [9:0] filt;
    wire [9:0] pins = {FUSE_CLOCK_OUTPUT_FUSE_I, FUSE_DIVIDE_BY_EIGHT_FUSE_I, FUSE_SUT_I, FUSE_CLOCK_SELECT_FUSES_I,
                       EXT_CLK_I, RC_CLK_I};
    always_ff @(posedge MCLK_I) begin
        sync0 <= pins;
        sync1 <= sync0;
        sync2 <= sync1;
        filt <= (sync1 & sync2) | (filt & (sync1 | sync2));
    end
    wire [1:0] osc_f = filt[1:0];
    wire [3:0] fuse_clock_select_fuses = filt[5:2];
    wire [1:0] fuse_sut = filt[7:6];
    wire fuse_div8 = filt[8];
    wire fuse_clock_output_fuse = filt[9];
    wire fuse_ext = (fuse_clock_select_fuses != RC_CFG_RESET);

    // Fuses caught once the synchroniser has settled after release
    logic [2:0] strap_cnt;
    logic loaded;
    wire fuse_load = (strap_cnt == STRAP_WAIT - 3'h1) && !loaded;
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            strap_cnt <= 3'h0;
            loaded <= 1'b0;
        end else begin
            if (!loaded)
                strap_cnt <= strap_cnt + 3'h1;
            if (fuse_load)
                loaded <= 1'b1;
        end
    end

    // Register decode
    wire wr_sel = WR_I && loaded && (ADDR_I == ADDR_SRC_SEL);
    wire wr_cfg = WR_I && loaded && (ADDR_I == ADDR_SRC_CFG);
    wire wr_div = WR_I && loaded && (ADDR_I == ADDR_DIV_CTL);

    logic [1:0] rc_sut;
    logic [1:0] ext_sut;
    logic rc_en;
    logic ext_en;
    logic cpu_sel;
    logic [3:0] rc_cfg;
    logic [3:0] ext_cfg;
    logic [3:0] div_sel;
    logic div_ce;
    logic [2:0] ce_cnt;

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rc_sut <= 2'h0;
            ext_sut <= 2'h0;
            rc_en <= 1'b1;
            ext_en <= 1'b0;
            cpu_sel <= 1'b0;
            rc_cfg <= RC_CFG_RESET;
            ext_cfg <= 4'h0;
        end else if (fuse_load) begin
            if (!fuse_ext)
                rc_sut <= fuse_sut;
            if (fuse_ext)
                ext_sut <= fuse_sut;
            if (fuse_ext)
                ext_cfg <= fuse_clock_select_fuses;
            cpu_sel <= fuse_ext;
            rc_en <= !fuse_ext;
            ext_en <= fuse_ext;
        end else begin
            if (wr_sel) begin
                ext_sut <= WDATA_I[EXT_SUT_LSB +: 2];
                rc_en <= WDATA_I[RC_EN_BIT];
                ext_en <= WDATA_I[EXT_EN_BIT];
                cpu_sel <= WDATA_I[CPU_SEL_BIT];
            end
            if (wr_cfg) begin
                // Stored as written; firmware keeps it at reset value
                rc_cfg <= WDATA_I[RC_CFG_LSB +: 4];
                ext_cfg <= WDATA_I[EXT_CFG_LSB +: 4];
            end
        end
    end

    // Divider protection
    wire ce_arm = wr_div && (WDATA_I == DIV_CE_ARM) && !div_ce;
    wire ps_wr = wr_div && !WDATA_I[DIV_CE_BIT] && div_ce;
    wire ps_legal = (WDATA_I[DIV_SEL_LSB +: 4] <= DIV_SEL_MAX);

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            div_sel <= DIV_SEL_DIV8;
            div_ce <= 1'b0;
            ce_cnt <= 3'h0;
        end else if (fuse_load) begin
            div_sel <= fuse_div8 ? DIV_SEL_DIV8 : DIV_SEL_DIV1;
        end else begin
            // Arm only with other bits zero; rewrite ignored
            if (ce_arm) begin
                div_ce <= 1'b1;
                ce_cnt <= CE_WINDOW;
            end else if (ps_wr || (div_ce && ce_cnt == 3'h1)) begin
                div_ce <= 1'b0;
                ce_cnt <= 3'h0;
            end else if (div_ce) begin
                ce_cnt <= ce_cnt - 3'h1;
            end
            // Second write takes the select; reserved codes dropped
            if (ps_wr && ps_legal)
                div_sel <= WDATA_I[DIV_SEL_LSB +: 4];
        end
    end

    // Oscillator activity monitors
    logic [1:0] run;
    logic [1:0] osc_prev;
    logic [3:0] edge_cnt [2];
    logic [9:0] idle_cnt [2];
    wire [1:0] osc_en = {ext_en, rc_en};
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_mon
            wire rise = osc_f[g] && !osc_prev[g];
            wire idle = (idle_cnt[g] >= 10'(STOP_CYCLES));
            always_ff @(posedge MCLK_I or negedge RST_N_I) begin
                if (!RST_N_I) begin
                    osc_prev[g] <= 1'b0;
                    edge_cnt[g] <= 4'h0;
                    idle_cnt[g] <= 10'h0;
                    run[g] <= 1'b0;
                end else begin
                    osc_prev[g] <= osc_f[g];
                    if (!osc_en[g] || idle)
                        edge_cnt[g] <= 4'h0;
                    else if (rise && edge_cnt[g] != 4'hf)
                        edge_cnt[g] <= edge_cnt[g] + 4'h1;
                    if (rise)
                        idle_cnt[g] <= 10'h0;
                    else if (!idle)
                        idle_cnt[g] <= idle_cnt[g] + 10'h1;
                    // Same monitor for the external source
                    run[g] <= osc_en[g] && !idle &&
                              (edge_cnt[g] >= 4'(START_EDGE_COUNT));
                end
            end
        end
    endgenerate

    // Glitch-free source switch
    mux_state_e mux_state;
    logic cur;
    logic low_seen;
    wire src_a = cur ? osc_f[1] : osc_f[0];
    wire mux_clk = (mux_state != MUX_ARM) && src_a;
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mux_state <= MUX_RUN;
            cur <= 1'b0;
            low_seen <= 1'b0;
        end else begin
            unique case (mux_state)
                MUX_RUN: begin
                    if (cpu_sel != cur)
                        mux_state <= MUX_DRAIN;
                end
                // Leave old source only while it is low
                MUX_DRAIN: begin
                    if (!src_a) begin
                        mux_state <= MUX_ARM;
                        cur <= cpu_sel;
                        low_seen <= 1'b0;
                    end
                end
                // Output held low until a clean rising edge
                MUX_ARM: begin
                    if (!src_a)
                        low_seen <= 1'b1;
                    else if (low_seen)
                        mux_state <= MUX_RUN;
                end
            endcase
        end
    end

    // Prescaler; new ratio applied only at a period boundary
    logic mux_prev;
    logic [3:0] div_act;
    logic [7:0] cnt;
    logic sys;
    wire [8:0] ratio = 9'h1 << div_act;
    wire [7:0] last = 8'(ratio - 9'h1);
    wire [7:0] half = 8'(ratio >> 1);
    wire mux_rise = mux_clk && !mux_prev;
    wire boundary = mux_rise && ((div_act == DIV_SEL_DIV1) || (cnt == last));
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mux_prev <= 1'b0;
            div_act <= DIV_SEL_DIV8;
            cnt <= 8'h0;
            sys <= 1'b0;
        end else begin
            mux_prev <= mux_clk;
            // Ratio changes at a full-period boundary only
            // Counter steps on undivided source edges
            if (boundary) begin
                cnt <= 8'h0;
                sys <= 1'b1;
                div_act <= div_sel;
            end else if (div_act == DIV_SEL_DIV1) begin
                sys <= mux_clk;
            end else if (mux_rise) begin
                cnt <= cnt + 8'h1;
                // Divided clock low for second half period
                if (cnt + 8'h1 == half)
                    sys <= 1'b0;
            end
        end
    end

    // Register outputs
    logic [1:0] ext_start_sut;
    wire [7:0] rd_sel = {rc_sut, ext_sut, rc_en, ext_en, 1'b0, cpu_sel};
    wire [7:0] rd_cfg = {rc_cfg, ext_cfg};
    wire [7:0] rd_sta = {6'h0, run[0], run[1]};
    wire [7:0] rd_div = {div_ce, 3'h0, div_sel};
    wire [7:0] rd_mux = (ADDR_I == ADDR_SRC_SEL) ? rd_sel :
                        (ADDR_I == ADDR_SRC_CFG) ? rd_cfg :
                        (ADDR_I == ADDR_OSC_STA) ? rd_sta : rd_div;
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RDATA_O <= 8'h00;
            RC_EN_O <= 1'b1;
            EXT_EN_O <= 1'b0;
            ext_start_sut <= 2'h0;
            SYS_CLK_O <= 1'b0;
        end else begin
            RDATA_O <= RD_I ? rd_mux : 8'h00;
            RC_EN_O <= rc_en;
            EXT_EN_O <= ext_en;
            // Start-up field sampled at each external start
            if (ext_en && !EXT_EN_O)
                ext_start_sut <= ext_sut;
            SYS_CLK_O <= sys;
        end
    end
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RC_SUT_O <= 2'h0;
            EXT_SUT_O <= 2'h0;
            RC_CLOCK_SELECT_FUSES_O <= RC_CFG_RESET;
            EXT_CLOCK_SELECT_FUSES_O <= 4'h0;
        end else begin
            RC_SUT_O <= rc_sut;
            EXT_SUT_O <= ext_start_sut;
            RC_CLOCK_SELECT_FUSES_O <= rc_cfg;
            EXT_CLOCK_SELECT_FUSES_O <= ext_cfg;
        end
    end

    // Clock output pin; unreset so the fuse-chosen source shows during reset
    wire in_rst = !RST_N_I || !loaded;
    wire dflt_src = fuse_ext ? osc_f[1] : osc_f[0];
    always_ff @(posedge MCLK_I) begin
        CLOCK_OUTPUT_PIN_O <= fuse_clock_output_fuse ? (in_rst ? dflt_src : sys) : GPIO_OUT_I;
        CLOCK_OUTPUT_PIN_OE_O <= fuse_clock_output_fuse || GPIO_OE_I;
    end

    a_rc_sut_locked: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        wr_sel |=> rc_sut == $past(rc_sut))
        else $error("rc start-up field changed by write");
    a_ext_sut_write: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        wr_sel && !ext_en && WDATA_I[EXT_EN_BIT] |=>
        ##2 EXT_SUT_O == $past(WDATA_I[EXT_SUT_LSB +: 2], 3))
        else $error("external start-up output wrong");
    a_rc_enable_pin: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        wr_sel |=> ##1 RC_EN_O == $past(WDATA_I[RC_EN_BIT], 2))
        else $error("rc enable not driven");
    a_selector_reset: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        $rose(loaded) |-> cpu_sel == $past(fuse_ext))
        else $error("selector not loaded from fuses");
    a_status_reserved: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        RD_I && ADDR_I == ADDR_OSC_STA |=> RDATA_O[7:2] == 6'h0 && RDATA_O[1] == $past(run[0]))
        else $error("status read wrong");
    a_rc_run_drop: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        !rc_en |=> !run[0])
        else $error("rc running with enable low");
    a_clock_output_pin_follow: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        fuse_clock_output_fuse && loaded ##1 $stable(fuse_clock_output_fuse) |-> CLOCK_OUTPUT_PIN_O == $past(sys) && CLOCK_OUTPUT_PIN_OE_O)
        else $error("clock output not divided clock");
    a_ce_window: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        $rose(div_ce) |-> ##4 !div_ce)
        else $error("change enable window not four cycles");
    a_select_write: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        wr_div && !div_ce |=> div_sel == $past(div_sel))
        else $error("select changed without arming");
    a_select_range: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        div_act <= DIV_SEL_MAX && div_sel <= DIV_SEL_MAX)
        else $error("reserved division code active");
    a_select_reset: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        $rose(loaded) |-> div_sel == ($past(fuse_div8) ? DIV_SEL_DIV8 : DIV_SEL_DIV1))
        else $error("select reset value wrong");
    a_switch_low: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        mux_state == MUX_DRAIN && !src_a |=> !mux_clk [*1] ##0 mux_state == MUX_ARM)
        else $error("switch did not hold clock low");
endmodule

// ---- clkctl_pkg.sv ----
package clkctl_pkg;
    // Register map, byte offsets on the 2-bit register port
    localparam logic [1:0] ADDR_SRC_SEL = 2'h0;
    localparam logic [1:0] ADDR_SRC_CFG = 2'h1;
    localparam logic [1:0] ADDR_OSC_STA = 2'h2;
    localparam logic [1:0] ADDR_DIV_CTL = 2'h3;
    // clock_source_select fields
    localparam int RC_SUT_LSB = 6;
    localparam int EXT_SUT_LSB = 4;
    localparam int RC_EN_BIT = 3;
    localparam int EXT_EN_BIT = 2;
    localparam int CPU_SEL_BIT = 0;
    // clock_source_config fields
    localparam int RC_CFG_LSB = 4;
    localparam int EXT_CFG_LSB = 0;
    // oscillator_running_status fields
    localparam int RC_RUN_BIT = 1;
    localparam int EXT_RUN_BIT = 0;
    // system_clock_divider_control fields
    localparam int DIV_CE_BIT = 7;
    localparam int DIV_SEL_LSB = 0;
    localparam logic [7:0] DIV_CE_ARM = 8'h80;
    // Reset and fuse-derived values
    localparam logic [3:0] RC_CFG_RESET = 4'h2;
    localparam logic [3:0] DIV_SEL_DIV8 = 4'h3;
    localparam logic [3:0] DIV_SEL_DIV1 = 4'h0;
    localparam logic [3:0] DIV_SEL_MAX = 4'h8;
    // Timing
    localparam logic [2:0] CE_WINDOW = 3'h4;
    localparam logic [2:0] STRAP_WAIT = 3'h5;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int STOP_TIME_NS = 1000;
    localparam int STOP_CYCLES = (STOP_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [3:0] START_EDGES = 4'h6;
    typedef enum {MUX_RUN, MUX_DRAIN, MUX_ARM} mux_state_e;
endpackage

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import clkctl_pkg::*;
    logic mclk, rst_n, wr_s, rd_s, rc_clk, ext_clk;
    logic [1:0] addr, fuse_sut;
    logic [7:0] wdata;
    logic [3:0] fuse_clock_select_fuses;
    logic fuse_div8, fuse_clock_output_fuse, gpio_out, gpio_oe;
    logic [7:0] rdata;
    logic rc_en, ext_en, sys_clk, clock_output_pin, clock_output_pin_oe;
    logic [1:0] rc_sut, ext_sut;
    logic [3:0] rc_clock_select_fuses, ext_clock_select_fuses;
    int err_total = 0;
    int n_compared = 0;
    int per;
    logic [7:0] prev;

    clock_switch_and_prescaler #(.START_EDGE_COUNT(6)) DUT (
        .MCLK_I(mclk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
        .FUSE_CLOCK_SELECT_FUSES_I(fuse_clock_select_fuses), .FUSE_SUT_I(fuse_sut), .FUSE_DIVIDE_BY_EIGHT_FUSE_I(fuse_div8),
        .FUSE_CLOCK_OUTPUT_FUSE_I(fuse_clock_output_fuse), .RC_CLK_I(rc_clk), .EXT_CLK_I(ext_clk),
        .GPIO_OUT_I(gpio_out), .GPIO_OE_I(gpio_oe), .RC_EN_O(rc_en), .EXT_EN_O(ext_en),
        .RC_SUT_O(rc_sut), .EXT_SUT_O(ext_sut), .RC_CLOCK_SELECT_FUSES_O(rc_clock_select_fuses),
        .EXT_CLOCK_SELECT_FUSES_O(ext_clock_select_fuses), .SYS_CLK_O(sys_clk), .CLOCK_OUTPUT_PIN_O(clock_output_pin), .CLOCK_OUTPUT_PIN_OE_O(clock_output_pin_oe)
    );

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Oscillators run only while enabled; periods 8 and 12 master cycles
    initial begin
        rc_clk = 1'b0;
        forever begin
            #16;
            rc_clk = (rc_en === 1'b1) ? ~rc_clk : 1'b0;
        end
    end
    initial begin
        ext_clk = 1'b0;
        forever begin
            #24;
            ext_clk = (ext_en === 1'b1) ? ~ext_clk : 1'b0;
        end
    end

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Write strobe stays high until the next call changes it
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        rd_s <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic idle;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd_chk(input logic [1:0] a, input logic [7:0] mask,
                          input logic [7:0] exp, input string what);
        logic [7:0] d;
        addr <= a;
        rd_s <= 1'b1;
        wr_s <= 1'b0;
        @(posedge mclk);
        rd_s <= 1'b0;
        #1 d = rdata;
        @(posedge mclk);
        chk(what, d & mask, exp);
    endtask

    task automatic to_rise(input bit pin, output int k);
        logic s, p;
        p = 1'b1;
        for (k = 1; k < 600; k++) begin
            @(posedge mclk);
            #1 s = pin ? clock_output_pin : sys_clk;
            if (s === 1'b1 && p === 1'b0) break;
            p = s;
        end
    endtask

    // First two rises only align to a settled divided clock
    task automatic measure(input bit pin, output int n);
        to_rise(pin, n);
        to_rise(pin, n);
        to_rise(pin, n);
        @(posedge mclk);
    endtask

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (6) @(posedge mclk);
    endtask

    initial begin
        #100000;
        err_total++;
        report_and_stop;
    end

    initial begin
        rst_n = 1'b0;
        wr_s = 1'b0;
        rd_s = 1'b0;
        addr = 2'h0;
        wdata = 8'h00;
        fuse_clock_select_fuses = 4'h2;
        fuse_sut = 2'h1;
        fuse_div8 = 1'b1;
        fuse_clock_output_fuse = 1'b1;
        gpio_out = 1'b0;
        gpio_oe = 1'b0;
        do_reset;
        rd_chk(ADDR_SRC_SEL, 8'hcf, 8'h48, "select after rc reset");
        rd_chk(ADDR_SRC_CFG, 8'hf0, 8'h20, "rc config reset");
        rd_chk(ADDR_DIV_CTL, 8'hff, 8'h03, "divider fuse reset");
        chk("rc startup out", {6'h0, rc_sut}, 8'h01);
        chk("rc config out", {4'h0, rc_clock_select_fuses}, 8'h02);
        repeat (100) @(posedge mclk);
        rd_chk(ADDR_OSC_STA, 8'hff, 8'h02, "rc running");
        measure(1'b0, per);
        chk("sys period div8", per[7:0], 8'd64);
        measure(1'b1, per);
        chk("clock_output_pin period div8", per[7:0], 8'd64);
        chk("clock_output_pin enable", {7'h0, clock_output_pin_oe}, 8'h01);
        prev = 8'h03;
        for (int c = 0; c < 9; c++) begin
            wr(ADDR_DIV_CTL, DIV_CE_ARM);
            rd_chk(ADDR_DIV_CTL, 8'hff, 8'h80 | prev, "change enable set");
            wr(ADDR_DIV_CTL, 8'(c));
            idle;
            rd_chk(ADDR_DIV_CTL, 8'hff, 8'(c), "divider code");
            if (c < 3) begin
                measure(1'b0, per);
                chk("sys period", per[7:0], 8'(8 << c));
            end
            prev = 8'(c);
        end
        // Arm refused when other bits are set
        wr(ADDR_DIV_CTL, 8'h81);
        wr(ADDR_DIV_CTL, 8'h01);
        idle;
        rd_chk(ADDR_DIV_CTL, 8'hff, 8'h08, "arm with extra bits");
        wr(ADDR_DIV_CTL, DIV_CE_ARM);
        wr(ADDR_DIV_CTL, 8'h09);
        idle;
        rd_chk(ADDR_DIV_CTL, 8'hff, 8'h08, "reserved code");
        // Rewrite of arm must not stretch the window
        wr(ADDR_DIV_CTL, DIV_CE_ARM);
        idle;
        wr(ADDR_DIV_CTL, DIV_CE_ARM);
        idle;
        idle;
        wr(ADDR_DIV_CTL, 8'h01);
        idle;
        rd_chk(ADDR_DIV_CTL, 8'hff, 8'h08, "window not extended");
        wr(ADDR_DIV_CTL, DIV_CE_ARM);
        wr(ADDR_DIV_CTL, 8'h00);
        wr(ADDR_SRC_SEL, 8'hc8);
        idle;
        rd_chk(ADDR_SRC_SEL, 8'hc0, 8'h40, "rc startup write ignored");
        // Wake-up order, enable then poll then select
        wr(ADDR_SRC_SEL, 8'h2c);
        idle;
        idle;
        chk("ext enable", {7'h0, ext_en}, 8'h01);
        repeat (100) @(posedge mclk);
        chk("ext startup latched", {6'h0, ext_sut}, 8'h02);
        rd_chk(ADDR_OSC_STA, 8'hff, 8'h03, "both running");
        wr(ADDR_SRC_CFG, 8'h2c);
        idle;
        rd_chk(ADDR_SRC_CFG, 8'hff, 8'h2c, "ext config write");
        wr(ADDR_SRC_SEL, 8'h2d);
        idle;
        measure(1'b0, per);
        chk("ext source period", per[7:0], 8'd12);
        wr(ADDR_SRC_SEL, 8'h25);
        idle;
        idle;
        chk("rc disabled", {7'h0, rc_en}, 8'h00);
        repeat (300) @(posedge mclk);
        wr(ADDR_OSC_STA, 8'hff);
        idle;
        rd_chk(ADDR_OSC_STA, 8'hff, 8'h01, "rc stopped");
        // Suspend order, enable RC, poll, select, stop external
        wr(ADDR_SRC_SEL, 8'h2d);
        idle;
        repeat (100) @(posedge mclk);
        rd_chk(ADDR_OSC_STA, 8'hff, 8'h03, "rc restarted");
        wr(ADDR_SRC_SEL, 8'h2c);
        wr(ADDR_SRC_SEL, 8'h28);
        idle;
        measure(1'b0, per);
        chk("rc source period", per[7:0], 8'd8);
        // Second reset with external source and no clock output
        fuse_clock_select_fuses <= 4'he;
        fuse_sut <= 2'h2;
        fuse_div8 <= 1'b0;
        fuse_clock_output_fuse <= 1'b0;
        gpio_out <= 1'b1;
        gpio_oe <= 1'b1;
        do_reset;
        rd_chk(ADDR_SRC_SEL, 8'h31, 8'h21, "select after ext reset");
        rd_chk(ADDR_SRC_CFG, 8'hff, 8'h2e, "config after ext reset");
        rd_chk(ADDR_DIV_CTL, 8'hff, 8'h00, "divider without fuse");
        chk("pin follows port", {6'h0, clock_output_pin_oe, clock_output_pin}, 8'h03);
        chk("ext config out", {4'h0, ext_clock_select_fuses}, 8'h0e);
        report_and_stop;
    end
endmodule
